// ===== ncpm_mapper.sv
// Operation
// - control byte 0: bit0 run forward, bit3 fault reset, bit5 network control.
// - status byte 0 faulted, warning, running, ready, from-net; byte 1 drive state.
// - with cyclic link and network control set, local commands are ignored.
// - reverse and reference requests ignored; their status bits read as zero.
// - two words from master in, two words to master out.
// - up to four master connections are served at once.
// - 256 bytes of process data in each direction.
// - register and process data addresses are zero based.
// - message boundary is line silence of 3.5 character times, no marker byte.
// - first character after such a gap starts a new message.
// - port indicator: off, green 100 Mbit/s, yellow 10 Mbit/s, flashing on activity.
// - network indicator: off, green, flashing green, red, flashing red as listed.
// - module indicator: green run, flashing green idle, red major, flashing red recoverable.
// - characters are 8 data bits, parity, one stop bit.
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module ncpm_mapper
    import ncpm_pkg::*;
#(
    parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYCLES
)(
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic      [31:0]          hrdata,
    output logic                      hresp,
    // Cyclic exchange with the fieldbus side
    input  wire logic                 cycUp,
    input  wire logic                 ctrlValid,
    input  wire ncpm_ctrl_pkt_t       ctrlPkt,
    input  wire logic                 statusReq,
    output ncpm_stat_pkt_t            statusPkt,
    output logic                      statusValid,
    // Connection requests
    input  wire logic                 connOpen,
    input  wire logic                 connClose,
    output logic                      connAccept,
    output logic                      connRefuse,
    // Process data
    input  wire logic                 pdRxWrEn,
    input  wire logic [PD_AW-1:0]     pdRxAddr,
    input  wire logic [31:0]          pdRxData,
    input  wire logic [PD_AW-1:0]     pdTxAddr,
    output logic      [31:0]          pdTxData,
    // Starter state and local commands
    input  wire logic                 drvFaulted,
    input  wire logic                 drvWarning,
    input  wire logic                 drvRunning,
    input  wire logic                 drvReady,
    input  wire logic [7:0]           drvState,
    input  wire logic                 localRunFwd,
    input  wire logic                 localFaultReset,
    output logic                      cmdRunFwd,
    output logic                      cmdFaultReset,
    output logic                      ctrlFromNet,
    // Serial line
    input  wire logic                 rtuRxd,
    output logic                      rtuMsgStart,
    // Indicators
    input  wire logic [1:0]           portLinkUp,
    input  wire logic [1:0]           portFast,
    input  wire logic [1:0]           portActivity,
    output logic [1:0]                linkLedGreen,
    output logic [1:0]                linkLedYellow,
    output logic                      netLedGreen,
    output logic                      netLedRed,
    output logic                      modLedGreen,
    output logic                      modLedRed
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [1:0] ledDrive(input ncpm_led_t mode, input logic blink);
        logic [1:0] ab;
        ab = 2'h0;
        unique case (mode)
            LED_OFF:     ab = 2'h0;
            LED_A_ON:    ab = 2'h1;
            LED_A_FLASH: ab = {1'b0, blink};
            LED_B_ON:    ab = 2'h2;
            LED_B_FLASH: ab = {blink, 1'b0};
            default:     ab = 2'h0;
        endcase
        return ab;
    endfunction : ledDrive

    function automatic logic inPage(input logic [11:0] a, input logic [3:0] page);
        return a[11:8] == page;
    endfunction : inPage

    // ****************************************************************
    // Register bus
    // ****************************************************************
    ncpm_bus_t                busState;
    logic                     wrActive;
    logic [11:0]              wrAddr;
    logic [11:0]              rdAddr;
    logic [6:0]               ctrlReg;
    logic [15:0]              bitDiv;
    logic [31:0]              msgCount;
    logic [31:0]              rxRdData;
    logic [31:0]              readMux;
    logic [2:0]               connCount;
    ncpm_ctrl_pkt_t           ctrlLatch;
    logic                     addrValid;
    logic                     txWrEn;
    logic                     rtuGapSeen;

    assign addrValid = hsel && hready && htrans[1];
    assign txWrEn    = wrActive && inPage(wrAddr, PAGE_TXPD);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busState  <= BUS_IDLE;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            rdAddr    <= 12'h000;
        end else begin
            unique case (busState)
                BUS_IDLE: begin
                    if (addrValid && !hwrite) begin
                        rdAddr    <= haddr[11:0];
                        hreadyout <= 1'b0;
                        busState  <= BUS_RDWAIT;
                    end
                end
                BUS_RDWAIT: begin
                    hrdata    <= readMux;
                    hreadyout <= 1'b1;
                    busState  <= BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrActive <= 1'b0;
            wrAddr   <= 12'h000;
        end else begin
            wrActive <= addrValid && hwrite;
            if (addrValid) begin
                wrAddr <= haddr[11:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrlReg <= CTRL_RESET;
            bitDiv  <= BIT_DIV_RESET;
        end else if (wrActive) begin
            if (wrAddr == ADDR_CTRL) begin
                ctrlReg <= hwdata[6:0];
            end
            if (wrAddr == ADDR_BITDIV) begin
                bitDiv <= hwdata[15:0];
            end
        end
    end

    // Register index equals byte address over four, counting from zero.
    always_comb begin
        readMux = 32'h0000_0000;
        if (inPage(rdAddr, PAGE_RXPD)) begin
            readMux = rxRdData;
        end else begin
            unique case (rdAddr)
                ADDR_CTRL:    readMux = {25'h0, ctrlReg};
                ADDR_STATUS:  readMux = {23'h0, rtuGapSeen, 1'b0, connCount, cycUp,
                                         ctrlFromNet, cmdFaultReset, cmdRunFwd};
                ADDR_BITDIV:  readMux = {16'h0000, bitDiv};
                ADDR_CTRLPKT: readMux = ctrlLatch;
                ADDR_STATPKT: readMux = statusPkt;
                ADDR_MSGCNT:  readMux = msgCount;
                default:      readMux = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Process data buffers
    // ****************************************************************
    // Master to device data, read by software at zero-based word index.
    ncpm_pd_ram u_rx_ram (
        .clk_sys (clk_sys),
        .wrEn    (pdRxWrEn),
        .wrAddr  (pdRxAddr),
        .wrData  (pdRxData),
        .rdAddr  (haddr[PD_AW+1:2]),
        .rdData  (rxRdData)
    );

    // Device to master data, written by software.
    ncpm_pd_ram u_tx_ram (
        .clk_sys (clk_sys),
        .wrEn    (txWrEn),
        .wrAddr  (wrAddr[PD_AW+1:2]),
        .wrData  (hwdata),
        .rdAddr  (pdTxAddr),
        .rdData  (pdTxData)
    );

    // ****************************************************************
    // Cyclic control and status
    // ****************************************************************
    logic netOwns;
    logic next_cmdRunFwd;
    logic next_cmdFaultReset;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrlLatch <= '0;
        end else if (ctrlValid) begin
            ctrlLatch <= ctrlPkt;
        end
    end

    // Only run, reset and network control are decoded; the rest is dropped.
    assign netOwns            = cycUp && ctrlLatch.netCtrl;
    assign next_cmdRunFwd     = netOwns ? ctrlLatch.runFwd
                                        : (localRunFwd || ctrlReg[CTRL_LOC_RUN]);
    assign next_cmdFaultReset = netOwns ? ctrlLatch.faultReset
                                        : (localFaultReset || ctrlReg[CTRL_LOC_RST]);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmdRunFwd     <= 1'b0;
            cmdFaultReset <= 1'b0;
            ctrlFromNet   <= 1'b0;
        end else begin
            cmdRunFwd     <= next_cmdRunFwd;
            cmdFaultReset <= next_cmdFaultReset;
            ctrlFromNet   <= netOwns;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            statusPkt   <= '0;
            statusValid <= 1'b0;
        end else begin
            statusValid <= statusReq;
            if (statusReq) begin
                statusPkt.spareWord   <= 16'h0000;
                statusPkt.driveState  <= drvState;
                statusPkt.zero76      <= 2'h0;
                statusPkt.ctrlFromNet <= netOwns;
                statusPkt.ready       <= drvReady;
                statusPkt.zero3       <= 1'b0;
                statusPkt.runningFwd  <= drvRunning;
                statusPkt.warning     <= drvWarning;
                statusPkt.faulted     <= drvFaulted;
            end
        end
    end

    // ****************************************************************
    // Master connections
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            connCount  <= 3'h0;
            connAccept <= 1'b0;
            connRefuse <= 1'b0;
        end else begin
            connAccept <= 1'b0;
            connRefuse <= 1'b0;
            if (connOpen && connClose) begin
                connAccept <= 1'b1;
            end else if (connOpen) begin
                if (connCount < MAX_CONN) begin
                    connCount  <= connCount + 3'h1;
                    connAccept <= 1'b1;
                end else begin
                    connRefuse <= 1'b1;
                end
            end else if (connClose && connCount != 3'h0) begin
                connCount <= connCount - 3'h1;
            end
        end
    end

    // ****************************************************************
    // Serial line silence detector
    // ****************************************************************
    logic        rxdMeta;
    logic        rxdSync;
    logic        rxdPrev;
    logic [15:0] halfCnt;
    logic        halfTick;
    logic [7:0]  idleHalf;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxdMeta <= 1'b1;
            rxdSync <= 1'b1;
            rxdPrev <= 1'b1;
        end else begin
            rxdMeta <= rtuRxd;
            rxdSync <= rxdMeta;
            rxdPrev <= rxdSync;
        end
    end

    // Half-bit ticks; one character is start, 8 data, parity and one stop bit.
    assign halfTick = (halfCnt + 16'h0001) >= {1'b0, bitDiv[15:1]};

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            halfCnt <= 16'h0000;
        end else if (halfTick) begin
            halfCnt <= 16'h0000;
        end else begin
            halfCnt <= halfCnt + 16'h0001;
        end
    end

    assign rtuGapSeen = idleHalf >= GAP_HALF_BITS;

    // Any line transition restarts the silence count.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idleHalf <= 8'h00;
        end else if (rxdSync != rxdPrev) begin
            idleHalf <= 8'h00;
        end else if (halfTick && !rtuGapSeen) begin
            idleHalf <= idleHalf + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rtuMsgStart <= 1'b0;
            msgCount    <= 32'h0000_0000;
        end else begin
            rtuMsgStart <= 1'b0;
            if (rxdPrev && !rxdSync && rtuGapSeen) begin
                rtuMsgStart <= 1'b1;
                msgCount    <= msgCount + 32'h0000_0001;
            end
        end
    end

    // ****************************************************************
    // Indicators
    // ****************************************************************
    logic [31:0] blinkCnt;
    logic        blink;
    ncpm_led_t   netMode;
    ncpm_led_t   modMode;
    logic [1:0]  netAb;
    logic [1:0]  modAb;
    logic [1:0]  linkAb [2];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            blinkCnt <= 32'h0000_0000;
            blink    <= 1'b0;
        end else if (blinkCnt >= 32'(BLINK_CYCLES - 1)) begin
            blinkCnt <= 32'h0000_0000;
            blink    <= !blink;
        end else begin
            blinkCnt <= blinkCnt + 32'h0000_0001;
        end
    end

    always_comb begin
        if (!ctrlReg[CTRL_IP_VALID]) begin
            netMode = LED_OFF;
        end else if (ctrlReg[CTRL_DUP_IP]) begin
            netMode = LED_B_ON;
        end else if (ctrlReg[CTRL_TIMEOUT]) begin
            netMode = LED_B_FLASH;
        end else if (connCount != 3'h0) begin
            netMode = LED_A_ON;
        end else begin
            netMode = LED_A_FLASH;
        end
        if (ctrlReg[CTRL_MAJ_FAULT]) begin
            modMode = LED_B_ON;
        end else if (drvWarning) begin
            modMode = LED_B_FLASH;
        end else if (cycUp) begin
            modMode = LED_A_ON;
        end else begin
            modMode = LED_A_FLASH;
        end
    end

    assign netAb = ledDrive(netMode, blink);
    assign modAb = ledDrive(modMode, blink);

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            if (!portLinkUp[p]) begin
                linkAb[p] = 2'h0;
            end else if (portFast[p]) begin
                linkAb[p] = ledDrive(portActivity[p] ? LED_A_FLASH : LED_A_ON, blink);
            end else begin
                linkAb[p] = ledDrive(portActivity[p] ? LED_B_FLASH : LED_B_ON, blink);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            netLedGreen   <= 1'b0;
            netLedRed     <= 1'b0;
            modLedGreen   <= 1'b0;
            modLedRed     <= 1'b0;
            linkLedGreen  <= 2'h0;
            linkLedYellow <= 2'h0;
        end else begin
            netLedGreen   <= netAb[0];
            netLedRed     <= netAb[1];
            modLedGreen   <= modAb[0];
            modLedRed     <= modAb[1];
            linkLedGreen  <= {linkAb[1][0], linkAb[0][0]};
            linkLedYellow <= {linkAb[1][1], linkAb[0][1]};
        end
    end

endmodule : ncpm_mapper

`default_nettype wire

// ===== ncpm_pkg.sv
package ncpm_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_MHZ           = 125;
    localparam int unsigned BLINK_HALF_MS     = 250;
    localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * CLK_MHZ * 1000;

    // ****************************************************************
    // Serial line framing and silence gap
    // ****************************************************************
    localparam int unsigned DATA_BITS      = 8;
    localparam int unsigned STOP_BITS      = 1;
    localparam int unsigned BITS_PER_CHAR  = 1 + DATA_BITS + 1 + STOP_BITS;
    localparam int unsigned GAP_CHARS_X2   = 7;
    localparam logic [7:0]  GAP_HALF_BITS  = 8'(GAP_CHARS_X2 * BITS_PER_CHAR);
    localparam logic [15:0] BIT_DIV_RESET  = 16'h32DC;

    // ****************************************************************
    // Connections and process data
    // ****************************************************************
    localparam logic [2:0]  MAX_CONN       = 3'h4;
    localparam int unsigned PD_BYTES       = 256;
    localparam int unsigned PD_WORDS       = PD_BYTES / 4;
    localparam int unsigned PD_AW          = $clog2(PD_WORDS);

    // ****************************************************************
    // Register map, byte addresses, zero based
    // ****************************************************************
    localparam logic [11:0] ADDR_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_STATUS    = 12'h004;
    localparam logic [11:0] ADDR_BITDIV    = 12'h008;
    localparam logic [11:0] ADDR_CTRLPKT   = 12'h00C;
    localparam logic [11:0] ADDR_STATPKT   = 12'h010;
    localparam logic [11:0] ADDR_MSGCNT    = 12'h014;
    localparam logic [3:0]  PAGE_RXPD      = 4'h1;
    localparam logic [3:0]  PAGE_TXPD      = 4'h2;
    localparam logic [6:0]  CTRL_RESET     = 7'h00;

    // CTRL register fields.
    localparam int unsigned CTRL_LOC_RUN   = 0;
    localparam int unsigned CTRL_LOC_RST   = 1;
    localparam int unsigned CTRL_IP_VALID  = 2;
    localparam int unsigned CTRL_DUP_IP    = 3;
    localparam int unsigned CTRL_TIMEOUT   = 4;
    localparam int unsigned CTRL_MAJ_FAULT = 5;
    localparam int unsigned CTRL_PAR_ODD   = 6;

    // ****************************************************************
    // Cyclic packets, two 16-bit words each way
    // ****************************************************************
    typedef struct packed {
        logic [15:0] refWord;
        logic [7:0]  spareByte;
        logic [1:0]  unused76;
        logic        netCtrl;
        logic        unused4;
        logic        faultReset;
        logic [1:0]  unused21;
        logic        runFwd;
    } ncpm_ctrl_pkt_t;

    typedef struct packed {
        logic [15:0] spareWord;
        logic [7:0]  driveState;
        logic [1:0]  zero76;
        logic        ctrlFromNet;
        logic        ready;
        logic        zero3;
        logic        runningFwd;
        logic        warning;
        logic        faulted;
    } ncpm_stat_pkt_t;

    typedef enum logic [2:0] {
        LED_OFF       = 3'b000,
        LED_A_ON      = 3'b001,
        LED_A_FLASH   = 3'b010,
        LED_B_ON      = 3'b011,
        LED_B_FLASH   = 3'b100
    } ncpm_led_t;

    typedef enum logic [0:0] {
        BUS_IDLE      = 1'b0,
        BUS_RDWAIT    = 1'b1
    } ncpm_bus_t;

endpackage : ncpm_pkg

// ===== ncpm_pd_ram.sv
`timescale 1ns/1ps
`default_nettype none

module ncpm_pd_ram
    import ncpm_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 wrEn,
    input  wire logic [PD_AW-1:0]     wrAddr,
    input  wire logic [31:0]          wrData,
    input  wire logic [PD_AW-1:0]     rdAddr,
    output logic      [31:0]          rdData
);

    logic [31:0] mem [PD_WORDS];

    always_ff @(posedge clk_sys) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk_sys) begin
        rdData <= mem[rdAddr];
    end

endmodule : ncpm_pd_ram

`default_nettype wire

// ===== ncpm_mapper_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ncpm_mapper_chk
    import ncpm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cycUp,
    input wire logic ctrlValid,
    input wire ncpm_ctrl_pkt_t ctrlPkt,
    input wire logic statusReq,
    input wire ncpm_stat_pkt_t statusPkt,
    input wire logic statusValid,
    input wire logic connOpen,
    input wire logic connClose,
    input wire logic connAccept,
    input wire logic connRefuse,
    input wire logic drvFaulted,
    input wire logic drvReady,
    input wire logic [7:0] drvState,
    input wire logic cmdRunFwd,
    input wire logic cmdFaultReset,
    input wire logic ctrlFromNet,
    input wire logic rtuRxd,
    input wire logic rtuMsgStart
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_status_answer: assert property (statusReq |=> statusValid)
        else $error("no status answer");
    a_status_bits: assert property (statusValid |-> statusPkt.faulted == $past(drvFaulted) &&
        statusPkt.ready == $past(drvReady) && statusPkt.driveState == $past(drvState))
        else $error("status bits wrong");
    a_unused_zero: assert property (statusValid |-> statusPkt.spareWord == 16'h0000 &&
        statusPkt.zero3 == 1'h0 && statusPkt.zero76 == 2'h0)
        else $error("unimplemented status set");
    a_net_owner: assert property (ctrlValid && cycUp ##1 !ctrlValid && cycUp |=>
        ctrlFromNet == $past(ctrlPkt.netCtrl, 2))
        else $error("net control flag wrong");
    a_net_command: assert property (ctrlValid && cycUp && ctrlPkt.netCtrl ##1 !ctrlValid && cycUp |=>
        cmdRunFwd == $past(ctrlPkt.runFwd, 2) && cmdFaultReset == $past(ctrlPkt.faultReset, 2))
        else $error("net command not obeyed");
    a_conn_answer: assert property (connOpen |=> connAccept != connRefuse)
        else $error("open not answered once");
    a_conn_quiet: assert property (!connOpen && !connClose |=> !connAccept && !connRefuse)
        else $error("answer without request");
    a_gap_start: assert property (rtuMsgStart |-> $past(rtuRxd, 3) == 1'h0 && $past(rtuRxd, 8) == 1'h1)
        else $error("start without falling edge");
endmodule : ncpm_mapper_chk
bind ncpm_mapper ncpm_mapper_chk chk_u (.*);
`default_nettype wire

// ===== ncpm_fb_master.sv
`timescale 1ns/1ps
`default_nettype none
module ncpm_fb_master
    import ncpm_pkg::*;
(
    input wire logic clk_sys,
    input wire ncpm_stat_pkt_t statusPkt,
    input wire logic statusValid,
    output logic cycUp,
    output logic ctrlValid,
    output ncpm_ctrl_pkt_t ctrlPkt,
    output logic statusReq
);
    initial begin
        {cycUp, ctrlValid, ctrlPkt, statusReq} = '0;
    end
    task automatic link(input logic up);
        cycUp <= up;
    endtask : link
    // Sends one two-word control packet; a gap models a slow master.
    task automatic send(input ncpm_ctrl_pkt_t pkt, input int gap);
        repeat (gap) @(posedge clk_sys);
        ctrlPkt <= pkt;
        ctrlValid <= 1'h1;
        @(posedge clk_sys);
        ctrlValid <= 1'h0;
        ctrlPkt <= ~pkt;
    endtask : send
    task automatic poll(output ncpm_stat_pkt_t st);
        int n;
        statusReq <= 1'h1;
        @(posedge clk_sys);
        statusReq <= 1'h0;
        n = 0;
        do @(posedge clk_sys); while (!statusValid && ++n < 8);
        st = statusPkt;
    endtask : poll
endmodule : ncpm_fb_master
`default_nettype wire

// ===== network_control_packet_mapper_test.sv
`timescale 1ns/1ps
`default_nettype none
module network_control_packet_mapper_test
    import ncpm_pkg::*;
;
    logic clk_sys, rst_n, hsel, hwrite, hready, hreadyout, hresp, cycUp, ctrlValid, statusReq, statusValid, own;
    logic connOpen, connClose, connAccept, connRefuse, pdRxWrEn, drvFaulted, drvWarning, drvRunning, drvReady;
    logic localRunFwd, localFaultReset, cmdRunFwd, cmdFaultReset, ctrlFromNet, rtuRxd, rtuMsgStart;
    logic netLedGreen, netLedRed, modLedGreen, modLedRed;
    logic [1:0] htrans, portLinkUp, portFast, portActivity, linkLedGreen, linkLedYellow;
    logic [2:0] hsize;
    logic [7:0] drvState;
    logic [31:0] haddr, hwdata, hrdata, pdRxData, pdTxData, r, d;
    logic [PD_AW-1:0] pdRxAddr, pdTxAddr, a;
    ncpm_ctrl_pkt_t ctrlPkt, p;
    ncpm_stat_pkt_t statusPkt, s;
    int fails, n_tests;
    assign hready = hreadyout;
    always #4 clk_sys = ~clk_sys;
    ncpm_mapper #(.BLINK_CYCLES(4)) dut_u (.*);
    ncpm_fb_master master_u (.*);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [31:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'h1;
        haddr <= adr;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk_sys); while (!hready);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (!hready);
        rd = hrdata;
    endtask : bus
    task automatic results();
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    initial begin
        clk_sys = 1'h0;
        rst_n = 1'h0;
        {hsel, hwrite, htrans, haddr, hwdata, connOpen, connClose, pdRxWrEn, pdRxAddr, pdRxData, pdTxAddr} = '0;
        {drvFaulted, drvWarning, drvRunning, drvReady, localRunFwd, localFaultReset, drvState} = '0;
        {portLinkUp, portFast, portActivity} = '0;
        hsize = 3'h2;
        rtuRxd = 1'h1;
        fails = 0;
        n_tests = 0;
        void'($urandom(16090));
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        bus(1'h0, 32'(ADDR_BITDIV), 32'h0, r);
        chk("bitDiv", 32'(BIT_DIV_RESET), r);
        bus(1'h0, 32'h0000003C, 32'h0, r);
        chk("unmapped", 32'h0, r);
        bus(1'h1, 32'(ADDR_BITDIV), 32'h4, r);
        for (int i = 0; i < 24; i++) begin
            p = $urandom;
            master_u.link($urandom_range(3) != 0);
            {drvFaulted, drvWarning, drvRunning, drvReady, localRunFwd, localFaultReset, portLinkUp, portFast,
                portActivity, drvState} <= 20'($urandom);
            master_u.send(p, i % 3);
            repeat (2) @(posedge clk_sys);
            own = cycUp & p.netCtrl;
            chk("cmd", 32'({own, own ? p.runFwd : localRunFwd, own ? p.faultReset : localFaultReset}),
                32'({ctrlFromNet, cmdRunFwd, cmdFaultReset}));
            master_u.poll(s);
            chk("status", {16'h0, drvState, 2'h0, own, drvReady, 1'h0, drvRunning, drvWarning, drvFaulted}, s);
            chk("link", {portLinkUp & portFast, portLinkUp & ~portFast} & ~{2{portActivity}},
                {linkLedGreen, linkLedYellow} & ~{2{portActivity}});
        end
        // Five opens on four slots, then open with close while full.
        for (int i = 0; i < 6; i++) begin
            connOpen <= 1'h1;
            connClose <= (i == 5);
            @(posedge clk_sys);
            connOpen <= 1'h0;
            connClose <= 1'h0;
            @(posedge clk_sys);
            chk("conn", 32'(i == 4 ? 2'h1 : 2'h2), 32'({connAccept, connRefuse}));
        end
        for (int i = 0; i < 4; i++) begin
            a = (i < 2) ? PD_AW'(i * 63) : PD_AW'($urandom);
            d = $urandom;
            pdRxAddr <= a;
            pdRxData <= d;
            pdRxWrEn <= 1'h1;
            @(posedge clk_sys);
            pdRxWrEn <= 1'h0;
            bus(1'h0, 32'h100 + 32'(a) * 4, 32'h0, r);
            chk("rxData", d, r);
            bus(1'h1, 32'h200 + 32'(a) * 4, ~d, r);
            pdTxAddr <= a;
            repeat (3) @(posedge clk_sys);
            chk("txData", ~d, pdTxData);
        end
        // Idle spans either side of 154 clocks, the gap at four clocks per bit.
        for (int i = 0; i < 3; i++) begin
            rtuRxd <= 1'h1;
            repeat (i == 1 ? 130 : 170) @(posedge clk_sys);
            rtuRxd <= 1'h0;
            repeat (20) @(posedge clk_sys);
        end
        bus(1'h0, 32'(ADDR_MSGCNT), 32'h0, r);
        chk("msgCount", 32'h2, r);
        results();
    end
    initial begin
        #100us;
        fails++;
        results();
    end
endmodule : network_control_packet_mapper_test
`default_nettype wire
